//--- verilog/rsos_defines.vh
// register map, field layout and timing constants of the servo output scheduler
`ifndef RSOS_DEFINES_VH
`define RSOS_DEFINES_VH
`define RSOS_CLK_MHZ        24'd250
`define RSOS_US_CYC         (`RSOS_CLK_MHZ)
`define RSOS_FRAME10_MS     24'd10
`define RSOS_FRAME20_MS     24'd20
`define RSOS_FRAME30_MS     24'd30
`define RSOS_MS_CYC         (24'd1000 * `RSOS_US_CYC)
`define RSOS_PULSE_MIN_US   12'd1000
`define RSOS_PULSE_NEU_US   12'd1500
`define RSOS_PULSE_MAX_US   12'd2000
`define RSOS_SUM_SEP_US     12'd400
`define RSOS_SUM_GAP_US     12'd4000
`define RSOS_NCH            16
`define RSOS_NSERVO         12
`define RSOS_TEMP_LO_MIN    -8'sd20
`define RSOS_TEMP_LO_MAX    8'sd10
`define RSOS_TEMP_HI_MIN    8'sd50
`define RSOS_TEMP_HI_MAX    8'sd80
`define RSOS_TEMP_LO_RST    8'hf6
`define RSOS_TEMP_HI_RST    8'h46
`define RSOS_MAXCH_MIN      5'd4
`define RSOS_MAXCH_MAX      5'd16
`define RSOS_MAXCH_RST      5'd8
`define RSOS_SUM_PIN_RST    4'd7
// output scheduling encodings
`define RSOS_MODE_SEQ       2'd0
`define RSOS_MODE_GRP       2'd1
`define RSOS_MODE_SUM_SIGNAL_IN_MODE      2'd2
`define RSOS_MODE_SUM_SIGNAL_OUT_MODE      2'd3
// register byte offsets
`define RSOS_A_CTRL         8'h00
`define RSOS_A_TEMP         8'h04
`define RSOS_A_SENS         8'h08
`define RSOS_A_FSAFE        8'h0c
`define RSOS_A_STAT         8'h10
`define RSOS_A_CHAN         8'h40
`define RSOS_A_FS           8'h80
`define RSOS_A_WIN          8'h40
// control register fields
`define RSOS_C_MODE         1:0
`define RSOS_C_PER          3:2
`define RSOS_C_BIG          4
`define RSOS_C_MAXCH        12:8
`define RSOS_C_SUMPIN       19:16
`define RSOS_PER_10         2'd0
`define RSOS_PER_20         2'd1
`endif

//--- verilog/rsos_scheduler.v
// servo pulse scheduler, sum-signal coupling, fail-safe and temperature alarm
`timescale 1ns/1ns
`include "rsos_defines.vh"
module rsos_scheduler (
  input  wire        ref_clk,       // 250 MHz clock
  input  wire        arst_n,        // async reset, active low
  input  wire [31:0] haddr,         // ahb address
  input  wire [1:0]  htrans,        // ahb transfer type
  input  wire        hwrite,        // ahb write
  input  wire [2:0]  hsize,         // ahb size
  input  wire [31:0] hwdata,        // ahb write data
  input  wire        hsel,          // ahb select
  input  wire        hready,        // ahb bus ready
  output wire [31:0] hrdata,        // ahb read data
  output wire        hreadyout,     // ahb slave ready
  output wire        hresp,         // ahb response, always okay
  input  wire        rfLinkOk,      // own radio reception good (pin)
  input  wire        sumIn,         // incoming sum signal (pin)
  input  wire        sensorPresent, // selected sensor connected (pin)
  input  wire [7:0]  tempMeas,      // measured temperature, signed degrees
  output reg  [11:0] servoOut,      // servo pulse outputs
  output reg         sumOutO,       // sum link pin output
  output reg         sumOutOe,      // sum link pin output enable
  output reg         alarmTone,     // continuous alarm tone
  output reg         tempErrInd,    // temperature error indicator on displays
  output reg         tempInvert,    // dataview temperature shown inverted
  output reg         telemTxEn,     // telemetry back to transmitter allowed
  output reg         sensArrow,     // extra right arrow on last screen
  output reg         sensAccess     // sensor settings reachable
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_PULSE = 3'b010;
  localparam ST_WAIT  = 3'b100;
  localparam SM_SEP   = 2'b01;
  localparam SM_HIGH  = 2'b10;
  localparam [23:0] FR10 = `RSOS_FRAME10_MS * `RSOS_MS_CYC - 24'd1;
  localparam [23:0] FR20 = `RSOS_FRAME20_MS * `RSOS_MS_CYC - 24'd1;
  localparam [23:0] FR30 = `RSOS_FRAME30_MS * `RSOS_MS_CYC - 24'd1;

  // microseconds to cycles, saturating not needed within 16 bits
  function [23:0] usCyc;
    input [15:0] us;
    begin
      usCyc = us * `RSOS_US_CYC;
    end
  endfunction

  // clamp a commanded width to the legal throw
  function [11:0] clampUs;
    input [11:0] v;
    begin
      if (v < `RSOS_PULSE_MIN_US)
        clampUs = `RSOS_PULSE_MIN_US;
      else if (v > `RSOS_PULSE_MAX_US)
        clampUs = `RSOS_PULSE_MAX_US;
      else
        clampUs = v;
    end
  endfunction

  // registers
  reg [19:0] ctrl;
  reg [7:0]  tempLo;
  reg [7:0]  tempHi;
  reg [3:0]  sensEn;
  reg [15:0] fsEn;
  reg [11:0] chanVal [0:15];
  reg [11:0] fsVal   [0:15];
  reg [11:0] inVal   [0:15];

  // pin synchronisers
  reg [1:0] linkSync;
  reg [1:0] sumSync;
  reg [1:0] sensSync;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      linkSync <= 2'h0;
      sumSync  <= 2'h0;
      sensSync <= 2'h0;
    end else begin
      linkSync <= {linkSync[0], rfLinkOk};
      sumSync  <= {sumSync[0], sumIn};
      sensSync <= {sensSync[0], sensorPresent};
    end
  end
  wire linkOk = linkSync[1];
  wire sumPin = sumSync[1];
  wire sensOk = sensSync[1];

  wire [1:0] mode   = ctrl[`RSOS_C_MODE];
  wire       isSumo = (mode == `RSOS_MODE_SUM_SIGNAL_OUT_MODE);
  wire       isSumi = (mode == `RSOS_MODE_SUM_SIGNAL_IN_MODE);
  wire       isGrp  = (mode == `RSOS_MODE_GRP);
  wire [4:0] maxCh  = ctrl[`RSOS_C_MAXCH];

  // ahb-lite slave: zero wait states
  reg        dWr;
  reg        dRd;
  reg [7:0]  dAddr;
  wire       aPhase = hsel & hready & htrans[1];
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dWr   <= 1'b0;
      dRd   <= 1'b0;
      dAddr <= 8'h00;
    end else begin
      dWr   <= aPhase & hwrite;
      dRd   <= aPhase & ~hwrite;
      dAddr <= haddr[7:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire chanHit = (dAddr >= `RSOS_A_CHAN) && (dAddr < `RSOS_A_CHAN + `RSOS_A_WIN);
  wire fsHit   = (dAddr >= `RSOS_A_FS) && (dAddr < `RSOS_A_FS + `RSOS_A_WIN);
  wire [3:0] dIdx = dAddr[5:2];
  wire signed [7:0] wLo = hwdata[7:0];
  wire signed [7:0] wHi = hwdata[15:8];
  wire [4:0] wMax = hwdata[12:8];
  integer i;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl   <= {`RSOS_SUM_PIN_RST, 3'h0, `RSOS_MAXCH_RST, 3'h0, 1'b0, `RSOS_PER_20, `RSOS_MODE_SEQ};
      tempLo <= `RSOS_TEMP_LO_RST;
      tempHi <= `RSOS_TEMP_HI_RST;
      sensEn <= 4'h0;
      fsEn   <= 16'h0000;
      for (i = 0; i < `RSOS_NCH; i = i + 1) begin
        chanVal[i] <= `RSOS_PULSE_NEU_US;
        fsVal[i]   <= `RSOS_PULSE_NEU_US;
      end
    end else if (dWr) begin
      if (dAddr == `RSOS_A_CTRL) begin
        ctrl[4:0]   <= hwdata[4:0];
        ctrl[19:16] <= hwdata[19:16];
        if (wMax < `RSOS_MAXCH_MIN)
          ctrl[`RSOS_C_MAXCH] <= `RSOS_MAXCH_MIN;
        else if (wMax > `RSOS_MAXCH_MAX)
          ctrl[`RSOS_C_MAXCH] <= `RSOS_MAXCH_MAX;
        else
          ctrl[`RSOS_C_MAXCH] <= wMax;
      end
      if (dAddr == `RSOS_A_TEMP) begin
        tempLo <= (wLo < `RSOS_TEMP_LO_MIN) ? `RSOS_TEMP_LO_MIN :
                  (wLo > `RSOS_TEMP_LO_MAX) ? `RSOS_TEMP_LO_MAX : wLo;
        tempHi <= (wHi < `RSOS_TEMP_HI_MIN) ? `RSOS_TEMP_HI_MIN :
                  (wHi > `RSOS_TEMP_HI_MAX) ? `RSOS_TEMP_HI_MAX : wHi;
      end
      if (dAddr == `RSOS_A_SENS)
        sensEn <= hwdata[3:0];
      if (dAddr == `RSOS_A_FSAFE)
        fsEn <= hwdata[15:0];
      if (chanHit)
        chanVal[dIdx] <= clampUs(hwdata[11:0]);
      if (fsHit)
        fsVal[dIdx] <= clampUs(hwdata[11:0]);
    end
  end

  // temperature alarm
  wire signed [7:0] tS  = tempMeas;
  wire signed [7:0] loS = tempLo;
  wire signed [7:0] hiS = tempHi;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarmTone  <= 1'b0;
      tempErrInd <= 1'b0;
      tempInvert <= 1'b0;
    end else begin
      alarmTone  <= (tS > hiS) || (tS < loS);
      tempErrInd <= (tS > hiS) || (tS < loS);
      tempInvert <= (tS > hiS) || (tS < loS);
    end
  end

  // sensor and telemetry flags
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      telemTxEn  <= 1'b0;
      sensArrow  <= 1'b0;
      sensAccess <= 1'b0;
    end else begin
      telemTxEn  <= linkOk & ~isSumi;
      sensAccess <= sensOk & linkOk & telemTxEn & (|sensEn);
      // arrow only for enabled, active sensor
      sensArrow  <= sensOk & (|sensEn);
    end
  end

  // sum-in decoder: high pulses separate channels, long low ends frame
  reg [23:0] inCnt;
  reg [4:0]  inIdx;
  reg        sumPrev;
  reg        sumValid;
  wire [23:0] inUs = inCnt / `RSOS_US_CYC;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      inCnt    <= 24'h0;
      inIdx    <= 5'h0;
      sumPrev  <= 1'b0;
      sumValid <= 1'b0;
      for (i = 0; i < `RSOS_NCH; i = i + 1)
        inVal[i] <= `RSOS_PULSE_NEU_US;
    end else begin
      sumPrev <= sumPin;
      if (sumPin & ~sumPrev) begin
        inCnt <= 24'h0;
        if (inCnt > usCyc({4'h0, `RSOS_PULSE_MAX_US + `RSOS_SUM_SEP_US}))
          inIdx <= 5'h0;
        else if (inIdx < `RSOS_NCH) begin
          inVal[inIdx[3:0]] <= clampUs(inUs[11:0]);
          inIdx <= inIdx + 5'd1;
          sumValid <= 1'b1;
        end
      end else if (inCnt != 24'hffffff)
        inCnt <= inCnt + 24'd1;
      if (inCnt > FR30)
        sumValid <= 1'b0;
    end
  end

  function [11:0] chanSel;
    input [3:0] c;
    begin
      if (linkOk)
        chanSel = chanVal[c];
      else if (isSumi && sumValid && (|fsEn))
        chanSel = inVal[c];
      else if (fsEn[c])
        chanSel = fsVal[c];
      else
        chanSel = chanVal[c];
    end
  endfunction

  // servo frame scheduler
  reg [2:0]  st;
  reg [23:0] frCnt;
  reg [23:0] pCnt;
  reg [3:0]  ch;
  reg [11:0] width [0:11];
  wire [23:0] frLen = (isGrp && ctrl[`RSOS_C_PER] == `RSOS_PER_10) ? FR10 :
                      ctrl[`RSOS_C_BIG] ? FR30 : FR20;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st       <= ST_IDLE;
      frCnt    <= 24'h0;
      pCnt     <= 24'h0;
      ch       <= 4'h0;
      servoOut <= 12'h000;
      for (i = 0; i < `RSOS_NSERVO; i = i + 1)
        width[i] <= `RSOS_PULSE_NEU_US;
    end else begin
      frCnt <= (frCnt >= frLen) ? 24'h0 : frCnt + 24'd1;
      case (st)
        ST_IDLE: begin
          if (frCnt == 24'h0) begin
            for (i = 0; i < `RSOS_NSERVO; i = i + 1)
              width[i] <= chanSel(i[3:0]);
            ch   <= 4'h0;
            pCnt <= 24'h0;
            st   <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          pCnt <= pCnt + 24'd1;
          if (isGrp) begin
            for (i = 0; i < 4; i = i + 1)
              servoOut[{ch[3:2], 2'b00} + i] <= (pCnt < usCyc({4'h0, width[{ch[3:2], 2'b00} + i]}));
            if (pCnt >= usCyc({4'h0, `RSOS_PULSE_MAX_US})) begin
              pCnt <= 24'h0;
              ch   <= ch + 4'd4;
              if (ch >= 4'd8)
                st <= ST_WAIT;
            end
          end else begin
            servoOut <= (pCnt < usCyc({4'h0, width[ch]})) ? (12'h001 << ch) : 12'h000;
            if (pCnt >= usCyc({4'h0, width[ch]})) begin
              pCnt <= 24'h0;
              ch   <= ch + 4'd1;
              if (ch == 4'd11)
                st <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          servoOut <= 12'h000;
          if (frCnt == frLen)
            st <= ST_IDLE;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // sum-out generator
  reg [1:0]  sm;
  reg [23:0] sCnt;
  reg [4:0]  sIdx;
  reg [11:0] sW;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sm       <= SM_SEP;
      sCnt     <= 24'h0;
      sIdx     <= 5'h0;
      sW       <= `RSOS_PULSE_NEU_US;
      sumOutO  <= 1'b0;
      sumOutOe <= 1'b0;
    end else begin
      sumOutOe <= isSumo;
      sCnt     <= sCnt + 24'd1;
      case (sm)
        SM_SEP: begin
          sumOutO <= 1'b1;
          if (sCnt >= usCyc({4'h0, `RSOS_SUM_SEP_US})) begin
            sCnt <= 24'h0;
            sW   <= (sIdx < maxCh) ? chanSel(sIdx[3:0]) - `RSOS_SUM_SEP_US : `RSOS_SUM_GAP_US;
            sm   <= SM_HIGH;
          end
        end
        SM_HIGH: begin
          sumOutO <= 1'b0;
          if (sCnt >= usCyc({4'h0, sW})) begin
            sCnt <= 24'h0;
            sIdx <= (sIdx >= maxCh) ? 5'h0 : sIdx + 5'd1;
            sm   <= SM_SEP;
          end
        end
        default: sm <= SM_SEP;
      endcase
    end
  end

  // read mux
  reg [31:0] rdat;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      rdat <= 32'h0;
    else if (aPhase & ~hwrite) begin
      case (haddr[7:0])
        `RSOS_A_CTRL:  rdat <= {12'h0, ctrl};
        `RSOS_A_TEMP:  rdat <= {16'h0, tempHi, tempLo};
        `RSOS_A_SENS:  rdat <= {28'h0, sensEn};
        `RSOS_A_FSAFE: rdat <= {16'h0, fsEn};
        `RSOS_A_STAT:  rdat <= {24'h0, sumValid, linkOk, sensOk, sensAccess, telemTxEn, tempErrInd, st[2], alarmTone};
        default: begin
          if (haddr[7:6] == 2'b01)
            rdat <= {20'h0, chanVal[haddr[5:2]]};
          else if (haddr[7:6] == 2'b10)
            rdat <= {20'h0, fsVal[haddr[5:2]]};
          else
            rdat <= 32'h0;
        end
      endcase
    end
  end
  assign hrdata = rdat;
endmodule

//--- verif/rsos_scheduler_sva.sv
// port assertions for the servo output scheduler
`timescale 1ns/1ns
`include "rsos_defines.vh"
module rsos_sched_sva (
  input wire        ref_clk,       // clock
  input wire        arst_n,        // reset, active low
  input wire [31:0] haddr,         // bus address
  input wire [1:0]  htrans,        // transfer type
  input wire        hwrite,        // write
  input wire [31:0] hwdata,        // write data
  input wire        hsel,          // select
  input wire        hready,        // bus ready
  input wire [31:0] hrdata,        // read data
  input wire        hreadyout,     // slave ready
  input wire        hresp,         // response
  input wire        rfLinkOk,      // own reception good
  input wire        sensorPresent, // sensor connected
  input wire [7:0]  tempMeas,      // temperature
  input wire        sumOutOe,      // sum link enable
  input wire        alarmTone,     // alarm tone
  input wire        tempErrInd,    // error indicator
  input wire        tempInvert,    // inverted display
  input wire        telemTxEn,     // telemetry allowed
  input wire        sensArrow,     // sensor arrow
  input wire        sensAccess     // sensor access
);
  wire signed [7:0] t      = tempMeas;
  wire              addrPh = hsel && hready && htrans[1];
  reg               ctrlWr;
  reg  [1:0]        mode;
  // mode is tracked from bus writes, so only its field is trusted here
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlWr <= 1'b0;
      mode <= `RSOS_MODE_SEQ;
    end else begin
      ctrlWr <= addrPh && hwrite && haddr == 32'h0;
      if (ctrlWr)
        mode <= hwdata[1:0];
    end
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  a_rdata_hold: assert property (!(addrPh && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_tone_ind: assert property (alarmTone == tempErrInd)
    else $error("tone and indicator differ");
  a_invert_alarm: assert property (tempInvert == alarmTone)
    else $error("inverted display not tied to alarm");
  a_hot_alarm: assert property ((t > 8'sd80) [*4] |-> alarmTone)
    else $error("no alarm above any high threshold");
  a_cold_alarm: assert property ((t < -8'sd20) [*4] |-> alarmTone)
    else $error("no alarm below any low threshold");
  a_mid_quiet: assert property ((t > 8'sd10 && t < 8'sd50) [*4] |-> !alarmTone)
    else $error("alarm inside every legal window");
  a_link_loss: assert property (!rfLinkOk [*5] |-> !telemTxEn && !sensAccess)
    else $error("telemetry or access without link");
  a_sum_signal_in_mode_telem: assert property ((mode == `RSOS_MODE_SUM_SIGNAL_IN_MODE) [*4] |-> !telemTxEn)
    else $error("sum-in receiver sends telemetry");
  a_oe_other: assert property ((mode != `RSOS_MODE_SUM_SIGNAL_OUT_MODE) [*4] |-> !sumOutOe)
    else $error("link driven outside sum-out");
  a_oe_sum_signal_out_mode: assert property ((mode == `RSOS_MODE_SUM_SIGNAL_OUT_MODE) [*4] |-> sumOutOe)
    else $error("sum-out does not drive the link");
  a_arrow_sensor: assert property (!sensorPresent [*5] |-> !sensArrow && !sensAccess)
    else $error("arrow without a sensor");
  c_alarm: cover property ($rose(alarmTone));
  c_sum_signal_out_mode: cover property ($rose(sumOutOe));
  c_access: cover property ($rose(sensAccess));
endmodule
bind rsos_scheduler rsos_sched_sva i_sva (.ref_clk, .arst_n, .haddr, .htrans, .hwrite, .hwdata, .hsel, .hready,
  .hrdata, .hreadyout, .hresp, .rfLinkOk, .sensorPresent, .tempMeas, .sumOutOe, .alarmTone, .tempErrInd,
  .tempInvert, .telemTxEn, .sensArrow, .sensAccess);

//--- verif/rsos_far_end.sv
// far side of the sum link: second receiver listening, servos as loads
`timescale 1ns/1ns
module rsos_far_end (
  input  wire ref_clk,  // clock
  input  wire arst_n,   // reset, active low
  input  wire sumOutO,  // link data from this receiver
  input  wire sumOutOe, // link driven by this receiver
  output wire sumIn     // resolved link level seen by this receiver
);
  reg lastDrv;
  // undriven link has no pull, so it shows the inverse of the last driven level
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      lastDrv <= 1'b1;
    else if (sumOutOe)
      lastDrv <= sumOutO;
  end
  assign sumIn = sumOutOe ? sumOutO : ~lastDrv;
endmodule

//--- verif/testbench.sv
// self-checking bench for the servo output scheduler
`timescale 1ns/1ns
`include "rsos_defines.vh"
module testbench;
  localparam [55:0] TV = 56'h551ee74746f5f6;
  localparam [6:0]  TA = 7'b1011010;
  reg         ref_clk, arst_n, hwrite, hsel, rfLinkOk, sensorPresent;
  reg  [31:0] haddr, hwdata, rd;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [7:0]  tempMeas;
  wire [31:0] hrdata;
  wire [11:0] servoOut;
  wire        hreadyout, hresp, sumIn, sumOutO, sumOutOe, alarmTone, tempErrInd;
  wire        tempInvert, telemTxEn, sensArrow, sensAccess;
  wire [6:0]  outs = {alarmTone, tempErrInd, tempInvert, telemTxEn, sensArrow, sensAccess, sumOutOe};
  integer     mismatches, comparisons, i;
  rsos_scheduler i_rsos_scheduler (.ref_clk, .arst_n, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hsel,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rfLinkOk, .sumIn, .sensorPresent, .tempMeas, .servoOut,
    .sumOutO, .sumOutOe, .alarmTone, .tempErrInd, .tempInvert, .telemTxEn, .sensArrow, .sensAccess);
  rsos_far_end i_rsos_far_end (.ref_clk, .arst_n, .sumOutO, .sumOutOe, .sumIn);
  task close_out;
    begin
      if (mismatches == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task miss(input string s);
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH at %0t: %0s", $time, s);
    end
  endtask
  task chk(input [31:0] g, e, input string s);
    begin
      comparisons = comparisons + 1;
      if (g !== e)
        miss(s);
    end
  endtask
  task waitRdy;
    int n;
    begin
      n = 0;
      do begin
        @(posedge ref_clk);
        n = n + 1;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
        miss("bus hang");
        close_out;
      end
    end
  endtask
  task xfer(input w, input [31:0] a, d);
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= a;
      waitRdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      waitRdy;
      rd = hrdata;
    end
  endtask
  task rdc(input [31:0] a, m, e, input string s);
    begin
      xfer(1'b0, a, 32'h0);
      chk(rd & m, e, s);
    end
  endtask
  task wrc(input [31:0] a, w, m, e, input string s);
    begin
      xfer(1'b1, a, w);
      rdc(a, m, e, s);
    end
  endtask
  // outputs must reach the value and then hold it for four cycles
  task waitOut(input [6:0] e, input string s);
    int n, k;
    begin
      n = 0;
      k = 0;
      while (k < 4 && n < 40) begin
        @(posedge ref_clk);
        n = n + 1;
        k = (outs === e) ? k + 1 : 0;
      end
      comparisons = comparisons + 1;
      if (k < 4)
        miss(s);
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    miss("run too long");
    close_out;
  end
  initial begin
    mismatches = 0;
    comparisons = 0;
    arst_n = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    hwrite = 1'b0;
    hsel = 1'b0;
    rfLinkOk = 1'b0;
    sensorPresent = 1'b0;
    tempMeas = 8'h1e;
    repeat (16) @(posedge ref_clk);
    chk({10'h0, servoOut, outs, sumOutO, hreadyout, hresp}, 32'h2, "outputs in reset");
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rdc(`RSOS_A_TEMP, 32'hffff, 32'h46f6, "temp reset");
    rdc(`RSOS_A_CTRL, 32'hf1f03, 32'h70800, "ctrl reset");
    wrc(`RSOS_A_TEMP, 32'h60e0, 32'hffff, 32'h50ec, "temp clamp out");
    wrc(`RSOS_A_TEMP, 32'h3020, 32'hffff, 32'h320a, "temp clamp in");
    wrc(`RSOS_A_CTRL, 32'h0200, 32'h1f00, 32'h0400, "maxch low");
    wrc(`RSOS_A_CTRL, 32'h1400, 32'h1f00, 32'h1000, "maxch high");
    wrc(`RSOS_A_CTRL, 32'h0b00, 32'h1f00, 32'h0b00, "maxch mid");
    wrc(`RSOS_A_CHAN, 32'd500, 32'hffff, 32'd1000, "width low");
    wrc(32'h6c, 32'd3000, 32'hffff, 32'd2000, "width high");
    wrc(32'h80, 32'd1500, 32'hffff, 32'd1500, "failsafe width");
    wrc(32'h20, 32'hffffffff, 32'hffffffff, 32'h0, "unmapped");
    wrc(`RSOS_A_TEMP, 32'h46f6, 32'hffff, 32'h46f6, "temp restore");
    wrc(`RSOS_A_CTRL, 32'h0804, 32'h3, 32'h0, "sequential, 20 ms");
    for (i = 0; i < 7; i = i + 1) begin
      tempMeas <= TV[55-8*i -: 8];
      waitOut({{3{TA[6-i]}}, 4'h0}, "temperature alarm");
    end
    tempMeas <= 8'h55;
    waitOut(7'h70, "hot alarm");
    rdc(`RSOS_A_STAT, 32'h7d, 32'h05, "status alarm");
    tempMeas <= 8'h1e;
    rfLinkOk <= 1'b1;
    sensorPresent <= 1'b1;
    wrc(`RSOS_A_SENS, 32'h1, 32'hf, 32'h1, "sensor enable");
    for (i = 0; i < 4; i = i + 1) begin
      wrc(`RSOS_A_CTRL, 32'h0804 | i, 32'h3, i, "mode field");
      waitOut({3'b000, i != 2, 1'b1, i != 2, i == 3}, "mode outputs");
      chk(servoOut, (i == 1) ? 32'hf : 32'h1, "servo start pattern");
    end
    rfLinkOk <= 1'b0;
    waitOut(7'b0000101, "link lost");
    rdc(`RSOS_A_STAT, 32'h7d, 32'h20, "status link lost");
    rfLinkOk <= 1'b1;
    wrc(`RSOS_A_SENS, 32'h0, 32'hf, 32'h0, "sensor disable");
    waitOut(7'b0001001, "pages hidden");
    wrc(`RSOS_A_SENS, 32'h1, 32'hf, 32'h1, "sensor enable");
    sensorPresent <= 1'b0;
    waitOut(7'b0001001, "sensor absent");
    sensorPresent <= 1'b1;
    waitOut(7'b0001111, "sensor reachable");
    rdc(`RSOS_A_STAT, 32'h7d, 32'h78, "status sensor");
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({10'h0, servoOut, outs, sumOutO, hreadyout, hresp}, 32'h2, "outputs in second reset");
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rdc(`RSOS_A_TEMP, 32'hffff, 32'h46f6, "temp after reset");
    rdc(`RSOS_A_CTRL, 32'h3, 32'h0, "mode after reset");
    chk(servoOut, 32'h1, "first channel after reset");
    close_out;
  end
endmodule
